/* File: pocr_consts.svh */
`ifndef POCR_CONSTS_SVH
`define POCR_CONSTS_SVH

// ==========================================================================
// Register addresses
`define POCR_ADDR_DEV_CONTROL 8'h0A
`define POCR_ADDR_MARGIN_HI 8'h10
`define POCR_ADDR_MARGIN_LO 8'h11
`define POCR_ADDR_DRV_CTL 8'h15
`define POCR_ADDR_SOFT_RST 8'h48

// ==========================================================================
// Field positions
`define POCR_BIT_PDN 6
`define POCR_BIT_SE_SEL 5
`define POCR_BIT_TRIG 1
`define POCR_BIT_AUTO 0
`define POCR_BIT_DIFF_PD 7
`define POCR_BIT_SOFT_RST 1

// ==========================================================================
// Reset values
`define POCR_RST_PDN 1'h0
`define POCR_RST_SE_SEL 1'h0
`define POCR_RST_TRIG 1'h0
`define POCR_RST_AUTO 1'h1
`define POCR_RST_DIFF_PD 1'h0
`define POCR_RST_DRV_SEL 2'h1
`define POCR_RST_MARGIN 10'h000

// ==========================================================================
// Timing
`define POCR_CAL_CYCLES 64

`endif

/* File: pocr_pkg.sv */
package pocr_pkg;

  // ========================================================================
  // Startup and calibration sequencer states
  typedef enum logic [2:0] {
    POCR_CONFIG,
    POCR_HALT,
    POCR_CAL,
    POCR_LOCK,
    POCR_RUN,
    POCR_PDN
  } pocr_state_t;

  // ========================================================================
  // Output driver format select
  typedef enum logic [1:0] {
    POCR_DRV_TRISTATE,
    POCR_DRV_LVPECL,
    POCR_DRV_LVDS,
    POCR_DRV_HCSL
  } pocr_drv_t;

endpackage : pocr_pkg

/* File: pocr_regs.sv */
`timescale 1ns/1ns
`include "pocr_consts.svh"


module pocr_regs #(
  parameter int CAL_CYCLES = `POCR_CAL_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial-port register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog lock indicator
  input wire logic pll_lock_in,
  // PLL and calibration controls
  output logic pll_enable,
  output logic cal_reset,
  output logic cal_busy,
  output logic outputs_enable,
  output logic device_reset,
  // Output stage controls
  output logic diff_buffer_power_down,
  output pocr_pkg::pocr_drv_t drv_sel,
  output logic [9:0] crystal_margin_offset
);
  import pocr_pkg::*;

  // ========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  wire wr_dev = reg_wr && hit(reg_addr, `POCR_ADDR_DEV_CONTROL); // Device control write
  wire wr_mhi = reg_wr && hit(reg_addr, `POCR_ADDR_MARGIN_HI); // Margin bits 1:0
  wire wr_mlo = reg_wr && hit(reg_addr, `POCR_ADDR_MARGIN_LO); // Margin bits 9:2
  wire wr_drv = reg_wr && hit(reg_addr, `POCR_ADDR_DRV_CTL); // Driver control write
  wire wr_srst = reg_wr && hit(reg_addr, `POCR_ADDR_SOFT_RST); // Soft reset write

  // ========================================================================
  // Storage
  logic synth_power_down; // Power-down control
  logic single_ended_sel; // Stored only, host keeps it zero
  logic calibration_trigger; // Self-clearing trigger
  logic auto_lock_on_reset; // Automatic lock after reset
  logic lock_meta; // Synchroniser first stage
  logic lock_sync; // Synchronised lock
  logic config_phase; // Sequencer in configuration
  logic cal_done; // Calibration finished pulse

  // Trigger edge, blocked while the reset configuration runs
  wire trig_rise = wr_dev && reg_wdata[`POCR_BIT_TRIG] && !calibration_trigger;
  wire cal_start = trig_rise && !config_phase && !device_reset;
  wire trig_set = cal_start;
  wire trig_clr = cal_done || device_reset || (wr_dev && !reg_wdata[`POCR_BIT_TRIG]);

  // Device control register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      synth_power_down <= `POCR_RST_PDN;
      single_ended_sel <= `POCR_RST_SE_SEL;
      auto_lock_on_reset <= `POCR_RST_AUTO;
    end else if (wr_dev) begin
      synth_power_down <= reg_wdata[`POCR_BIT_PDN];
      single_ended_sel <= reg_wdata[`POCR_BIT_SE_SEL];
      auto_lock_on_reset <= reg_wdata[`POCR_BIT_AUTO];
    end
  end

  // Trigger bit: a new start wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      calibration_trigger <= `POCR_RST_TRIG;
    end else if (trig_set) begin
      calibration_trigger <= 1'b1;
    end else if (trig_clr) begin
      calibration_trigger <= 1'b0;
    end
  end

  // Soft reset pulse, register reads back zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= wr_srst && reg_wdata[`POCR_BIT_SOFT_RST];
    end
  end

  // Margin offset parts, bits 1:0 and 9:2
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      crystal_margin_offset <= `POCR_RST_MARGIN;
    end else begin
      if (wr_mhi) crystal_margin_offset[1:0] <= reg_wdata[1:0];
      if (wr_mlo) crystal_margin_offset[9:2] <= reg_wdata;
    end
  end

  // Output driver control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      diff_buffer_power_down <= `POCR_RST_DIFF_PD;
      drv_sel <= pocr_drv_t'(`POCR_RST_DRV_SEL);
    end else if (wr_drv) begin
      diff_buffer_power_down <= reg_wdata[`POCR_BIT_DIFF_PD];
      drv_sel <= pocr_drv_t'(reg_wdata[1:0]);
    end
  end

  // Lock input synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= pll_lock_in;
      lock_sync <= lock_meta;
    end
  end

  // ========================================================================
  // Read-back
  logic [7:0] rd_mux; // Selected read value
  always_comb begin
    rd_mux = 8'h00; // Unmapped and reserved read zero
    unique case (1'b1)
      hit(reg_addr, `POCR_ADDR_DEV_CONTROL): begin
        rd_mux[`POCR_BIT_PDN] = synth_power_down;
        rd_mux[`POCR_BIT_SE_SEL] = single_ended_sel;
        rd_mux[`POCR_BIT_TRIG] = calibration_trigger;
        rd_mux[`POCR_BIT_AUTO] = auto_lock_on_reset;
      end
      hit(reg_addr, `POCR_ADDR_MARGIN_HI): rd_mux[1:0] = crystal_margin_offset[1:0];
      hit(reg_addr, `POCR_ADDR_MARGIN_LO): rd_mux = crystal_margin_offset[9:2];
      hit(reg_addr, `POCR_ADDR_DRV_CTL): begin
        rd_mux[`POCR_BIT_DIFF_PD] = diff_buffer_power_down;
        rd_mux[1:0] = drv_sel;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data register, held until next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ========================================================================
  // Startup and calibration sequencer
  pocr_seq #(
    .CAL_CYCLES(CAL_CYCLES)
  ) u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .dev_reset(device_reset),
    .synth_power_down(synth_power_down),
    .auto_lock_on_reset(auto_lock_on_reset),
    .cal_start(cal_start),
    .lock_in(lock_sync),
    .config_phase(config_phase),
    .pll_enable(pll_enable),
    .cal_reset(cal_reset),
    .cal_busy(cal_busy),
    .outputs_enable(outputs_enable),
    .cal_done(cal_done)
  );

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_TRIG_STARTS_CAL: assert property (
    cal_start && !synth_power_down |=> cal_busy && calibration_trigger)
    else $error("trigger edge did not start calibration");
  AST_TRIG_SELF_CLEAR: assert property (
    cal_done && !trig_set |=> !calibration_trigger)
    else $error("trigger not cleared at calibration end");
  AST_CONFIG_PRECEDENCE: assert property (
    config_phase && wr_dev && reg_wdata[`POCR_BIT_TRIG] |=> !calibration_trigger)
    else $error("trigger acted during reset configuration");
  AST_SOFT_RESET: assert property (
    wr_srst && reg_wdata[`POCR_BIT_SOFT_RST] |=> device_reset ##1 (config_phase && !device_reset))
    else $error("soft reset did not restart configuration");
  AST_MARGIN_SPLIT: assert property (
    wr_mlo && !wr_mhi |=> crystal_margin_offset[9:2] == $past(reg_wdata)
    && crystal_margin_offset[1:0] == $past(crystal_margin_offset[1:0]))
    else $error("margin offset high bits wrong");
  AST_DRV_WRITE: assert property (
    wr_drv |=> diff_buffer_power_down == $past(reg_wdata[`POCR_BIT_DIFF_PD])
    && drv_sel == pocr_drv_t'($past(reg_wdata[1:0])))
    else $error("driver control not stored");
  AST_RSVD_ZERO: assert property (
    reg_rd && hit(reg_addr, `POCR_ADDR_DRV_CTL) |=> reg_rdata[6:2] == 5'h00)
    else $error("reserved bits read non-zero");

endmodule : pocr_regs

/* File: pocr_seq.sv */
`timescale 1ns/1ns
`include "pocr_consts.svh"

module pocr_seq #(
  parameter int CAL_CYCLES = `POCR_CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Controls from the register bank
  input wire logic dev_reset,
  input wire logic synth_power_down,
  input wire logic auto_lock_on_reset,
  input wire logic cal_start,
  input wire logic lock_in,
  // Sequencer outputs
  output logic config_phase,
  output logic pll_enable,
  output logic cal_reset,
  output logic cal_busy,
  output logic outputs_enable,
  output logic cal_done
);
  import pocr_pkg::*;

  localparam int CNT_W = (CAL_CYCLES > 1) ? $clog2(CAL_CYCLES) : 1;

  // ========================================================================
  // State and counter
  pocr_state_t state_reg; // Current state
  pocr_state_t state_next; // Next state
  logic [CNT_W-1:0] cnt_reg; // Calibration time counter
  logic [CNT_W-1:0] cnt_next;
  wire cnt_last = (cnt_reg == CNT_W'(CAL_CYCLES - 1)); // Last calibration cycle
  wire cal_fin = (state_reg == POCR_CAL) && cnt_last; // Calibration completes

  // Next-state decision
  always_comb begin
    state_next = state_reg;
    if (dev_reset) begin
      // Any device reset restarts the configuration phase
      state_next = POCR_CONFIG;
    end else if (synth_power_down && state_reg != POCR_CONFIG) begin
      state_next = POCR_PDN;
    end else begin
      unique case (state_reg)
        POCR_CONFIG: begin
          // Startup setting chosen, trigger not consulted here
          if (synth_power_down) state_next = POCR_PDN;
          else if (auto_lock_on_reset) state_next = POCR_CAL;
          else state_next = POCR_HALT;
        end
        POCR_HALT, POCR_LOCK, POCR_RUN: begin
          if (cal_start) state_next = POCR_CAL;
          else if (state_reg == POCR_LOCK && lock_in) state_next = POCR_RUN;
          else if (state_reg == POCR_RUN && !lock_in) state_next = POCR_LOCK;
        end
        POCR_CAL: begin
          if (cnt_last) state_next = POCR_LOCK;
        end
        POCR_PDN: begin
          // Power-down released: enable and recalibrate
          state_next = POCR_CAL;
        end
      endcase
    end
  end

  assign cnt_next = (state_reg == POCR_CAL && state_next == POCR_CAL) ? cnt_reg + 1'b1 : '0;

  // State, counter and registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= POCR_CONFIG;
      cnt_reg <= '0;
      config_phase <= 1'b1;
      pll_enable <= 1'b0;
      cal_reset <= 1'b0;
      cal_busy <= 1'b0;
      outputs_enable <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      config_phase <= (state_next == POCR_CONFIG);
      pll_enable <= (state_next != POCR_PDN) && (state_next != POCR_CONFIG);
      cal_reset <= (state_next == POCR_PDN);
      cal_busy <= (state_next == POCR_CAL);
      outputs_enable <= (state_next == POCR_RUN);
      cal_done <= cal_fin && !dev_reset && !synth_power_down;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_cal_finish;
    (state_reg == POCR_CAL) && cnt_last && !synth_power_down && !dev_reset;
  endsequence

  sequence s_done_pulse;
    cal_done ##1 !cal_done;
  endsequence

  AST_PDN_HOLDS_CAL: assert property (
    synth_power_down && !dev_reset && state_reg != POCR_CONFIG |=> cal_reset && !pll_enable)
    else $error("power-down did not stop the PLL");
  AST_PDN_RESTART: assert property (
    state_reg == POCR_PDN && !synth_power_down && !dev_reset |=> cal_busy && pll_enable)
    else $error("calibration not restarted after power-down");
  AST_AUTO_START: assert property (
    state_reg == POCR_CONFIG && !dev_reset && !synth_power_down && auto_lock_on_reset
    |=> cal_busy)
    else $error("automatic start did not calibrate");
  AST_HALT_NO_AUTO: assert property (
    state_reg == POCR_CONFIG && !dev_reset && !synth_power_down && !auto_lock_on_reset
    |=> !cal_busy && !outputs_enable)
    else $error("sequence did not halt after configuration");
  AST_CFG_PDN: assert property (
    state_reg == POCR_CONFIG && !dev_reset && synth_power_down |=> cal_reset && !cal_busy)
    else $error("power-down setting ignored after reset");
  AST_DONE_AFTER_CAL: assert property (
    s_cal_finish |=> s_done_pulse)
    else $error("calibration end not flagged for one cycle");
  AST_LOCK_ENABLES: assert property (
    state_reg == POCR_LOCK && lock_in && !cal_start && !synth_power_down && !dev_reset
    |=> outputs_enable ##1 (outputs_enable || !lock_in || cal_busy || cal_reset
    || config_phase))
    else $error("outputs not enabled on lock");

endmodule : pocr_seq

/* File: tb_pll_output_control_regs.sv */
`timescale 1ns/1ns

module tb_pll_output_control_regs;
  import pocr_pkg::*;

  // ==========================================================================
  // Settings and register places
  localparam int CAL_N = 4; // Shortened calibration length
  localparam logic [7:0] A_DEV = 8'h0A; // Device control
  localparam logic [7:0] A_MHI = 8'h10; // Margin offset, low two bits
  localparam logic [7:0] A_MLO = 8'h11; // Margin offset, upper eight bits
  localparam logic [7:0] A_DRV = 8'h15; // Output driver control
  localparam logic [7:0] A_SRST = 8'h48; // Soft reset strobe
  localparam logic [7:0] A_NONE = 8'h20; // Unmapped place

  // ==========================================================================
  // Stimulus, observed outputs and counters
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pll_lock_in = 1'b0;
  logic [7:0] reg_rdata;
  logic pll_enable;
  logic cal_reset;
  logic cal_busy;
  logic outputs_enable;
  logic device_reset;
  logic diff_buffer_power_down;
  pocr_drv_t drv_sel;
  logic [9:0] crystal_margin_offset;
  int fail_count = 0;
  int checks = 0;

  // Free-running system clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // Design under test with a short calibration
  pocr_regs #(.CAL_CYCLES(CAL_N)) i_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pll_lock_in(pll_lock_in),
    .pll_enable(pll_enable),
    .cal_reset(cal_reset),
    .cal_busy(cal_busy),
    .outputs_enable(outputs_enable),
    .device_reset(device_reset),
    .diff_buffer_power_down(diff_buffer_power_down),
    .drv_sel(drv_sel),
    .crystal_margin_offset(crystal_margin_offset)
  );

  // ==========================================================================
  // Helpers
  // Step just past the next rising edge
  task automatic tick;
    @(posedge clk_sys);
    #2;
  endtask : tick

  // Verdict and end of run
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Register write; idle cycle after keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask : wr

  // Register read and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    v = reg_rdata;
    tick();
    check(16'(v), 16'(exp), what);
  endtask : rdchk

  // Pick one observed output by number
  function automatic logic sig(input int which);
    case (which)
      0: sig = cal_busy;
      1: sig = outputs_enable;
      default: sig = device_reset;
    endcase
  endfunction : sig

  // Bounded wait for a level; running out ends the run
  task automatic wait_sig(input int which, input logic lvl, input int bound);
    int k;
    k = 0;
    checks++;
    while (sig(which) !== lvl && k < bound) begin
      tick();
      k++;
    end
    if (sig(which) !== lvl) begin
      fail_count++;
      $display("MISMATCH t=%0t wait ran out on output %0d", $time, which);
      wrap_up();
    end
  endtask : wait_sig

  // Full calibration then lock
  task automatic finish_cal;
    wait_sig(0, 1'b0, CAL_N + 4);
    wait_sig(1, 1'b1, 8);
  endtask : finish_cal

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) tick();
    rst = 1'b0;
    // Start-up with defaults calibrates and locks on its own
    wait_sig(0, 1'b1, 4);
    check(16'(pll_enable), 16'h0001, "pll on after reset");
    pll_lock_in = 1'b1;
    finish_cal();
    rdchk(A_DEV, 8'h01, "device control default");
    rdchk(A_MHI, 8'h00, "margin low default");
    rdchk(A_MLO, 8'h00, "margin high default");
    rdchk(A_DRV, 8'h01, "driver control default");
    check(16'(drv_sel), 16'(POCR_DRV_LVPECL), "driver default");
    check(16'(diff_buffer_power_down), 16'h0000, "buffer default");
    // Every driver format, buffer bit toggled, reserved bits written
    for (int s = 0; s < 4; s++) begin
      wr(A_DRV, {s[0], 5'h1F, s[1:0]});
      rdchk(A_DRV, {s[0], 5'h00, s[1:0]}, "driver control");
      check(16'(drv_sel), 16'(s[1:0]), "driver select");
      check(16'(diff_buffer_power_down), 16'(s[0]), "buffer power down");
    end
    // Margin offset split over two places
    wr(A_MHI, 8'hFE);
    rdchk(A_MHI, 8'h02, "margin low bits");
    wr(A_MLO, 8'hA5);
    rdchk(A_MLO, 8'hA5, "margin high bits");
    check(16'(crystal_margin_offset), 16'h0296, "margin value");
    wr(A_MHI, 8'h01);
    wr(A_NONE, 8'hFF);
    check(16'(crystal_margin_offset), 16'h0295, "margin low update");
    rdchk(A_NONE, 8'h00, "unmapped read");
    rdchk(A_SRST, 8'h00, "strobe place read");
    // Reserved device control bits, single-ended select kept low
    wr(A_DEV, 8'h9D);
    rdchk(A_DEV, 8'h01, "device control reserved");
    // Power down then back up
    wr(A_DEV, 8'h41);
    check(16'(cal_reset), 16'h0001, "cal held in reset");
    check(16'(pll_enable), 16'h0000, "pll off");
    check(16'(outputs_enable), 16'h0000, "outputs off");
    check(16'(cal_busy), 16'h0000, "no calibration");
    rdchk(A_DEV, 8'h41, "power down reads back");
    wr(A_DEV, 8'h01);
    check(16'(cal_reset), 16'h0000, "cal reset released");
    wait_sig(0, 1'b1, 4);
    check(16'(pll_enable), 16'h0001, "pll back on");
    finish_cal();
    // Host trigger; bit clears when done
    wr(A_DEV, 8'h03);
    wait_sig(0, 1'b1, 4);
    finish_cal();
    rdchk(A_DEV, 8'h01, "trigger cleared");
    // Losing lock drops the outputs
    pll_lock_in = 1'b0;
    wait_sig(1, 1'b0, 6);
    pll_lock_in = 1'b1;
    wait_sig(1, 1'b1, 6);
    // Auto-lock off: soft reset halts until the host triggers
    wr(A_DEV, 8'h00);
    reg_addr = A_SRST;
    reg_wdata = 8'h02;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    wait_sig(2, 1'b1, 3);
    repeat (10) tick();
    check(16'(cal_busy), 16'h0000, "halted, no calibration");
    check(16'(outputs_enable), 16'h0000, "halted, outputs off");
    rdchk(A_DRV, 8'h83, "registers kept");
    wr(A_DEV, 8'h02);
    wait_sig(0, 1'b1, 4);
    finish_cal();
    // Auto-lock on: soft reset restarts; trigger in configuration ignored
    wr(A_DEV, 8'h01);
    wr(A_SRST, 8'h02);
    wr(A_DEV, 8'h03);
    wait_sig(0, 1'b1, 6);
    rdchk(A_DEV, 8'h01, "trigger ignored in configuration");
    finish_cal();
    rdchk(A_DEV, 8'h01, "trigger low after restart");
    // Power-down kept through a soft reset leaves the PLL off
    wr(A_DEV, 8'h41);
    wr(A_SRST, 8'h02);
    repeat (3) tick();
    check(16'(cal_reset), 16'h0001, "cal reset after restart");
    check(16'(pll_enable), 16'h0000, "pll off after restart");
    check(16'(cal_busy), 16'h0000, "no automatic calibration");
    wr(A_DEV, 8'h01);
    wait_sig(0, 1'b1, 4);
    finish_cal();
    wrap_up();
  end

endmodule : tb_pll_output_control_regs
